// ### rtl/rate_pin_pkg.sv
// Package for the rate-reduce pin status and active-control shadow block.
// Assumes a 10 MHz device clock and a host command decoder outside.
//
// Functional notes
// - Status bit 7 shows present pin level
// - Rise-seen sticky, cleared by full/global update
// - Fall-seen sticky, cleared by full/global update
// - Rising edge triggers enabled limited update
// - Falling edge triggers enabled limited update
// - Full update wins when both enabled
// - Edge enables change only by host write
// - Both load results; full also zeroes accumulators
// - Limited updates never activate pending control
// - Status reads zero in alert-pin mode
// - Reading status clears nothing
// - Power-cycle flag set at reset, host clears
// - Shadow is read-only, shows active settings
// - Shadow loads with results after 1 ms
// - Rate change waits for conversion cycle end unless active sleep bit set
// - Two-bit rate field selects normal rate
// - Active sleep bit stops conversions
// - Single-shot bit selects conversion mode
// - Alert-pin bit enables alert output
// - Conversion-complete alert lasts 5 us
// - Overflow alert drives output on overflow
// - Overflow flag reads one after overflow
// - Keep update refreshes results, keeps accumulators

package rate_pin_pkg;

  //////////////////////////////////////////////////////////////////////////
  // Register offsets
  localparam logic [7:0] ADDR_PIN_STAT = 8'h20;
  localparam logic [7:0] ADDR_ACT_CTRL = 8'h21;

  //////////////////////////////////////////////////////////////////////////
  // Pin status register fields
  localparam int BIT_LEVEL = 7;
  localparam int BIT_RISE_SEEN = 6;
  localparam int BIT_FALL_SEEN = 5;
  localparam int BIT_RISE_FULL = 4;
  localparam int BIT_RISE_KEEP = 3;
  localparam int BIT_FALL_FULL = 2;
  localparam int BIT_FALL_KEEP = 1;
  localparam int BIT_POR = 0;
  // Enable bits 4:1 reset value
  localparam logic [3:0] EN_RESET = 4'ha;

  //////////////////////////////////////////////////////////////////////////
  // Active control fields
  localparam int BIT_RATE_HI = 7;
  localparam int BIT_RATE_LO = 6;
  localparam int BIT_SLEEP = 5;
  localparam int BIT_SINGLE = 4;
  localparam int BIT_ALERT_PIN = 3;
  localparam int BIT_CC_ALERT = 2;
  localparam int BIT_OVERFLOW_ALERT_EN = 1;
  localparam int BIT_OVF = 0;
  localparam logic [6:0] ACT_RESET = 7'h00;

  //////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int UPD_DELAY_US = 1000;
  localparam int UPD_CYCLES = (UPD_DELAY_US * 1000) / CLK_PERIOD_NS;
  localparam int CC_ALERT_NS = 5000;
  localparam int CC_CYCLES = (CC_ALERT_NS + CLK_PERIOD_NS - 1)
                             / CLK_PERIOD_NS;
  localparam int SYNC_STAGES = 2;

  // Host update sequencer states
  typedef enum logic [1:0] {UPD_IDLE, UPD_WAIT_CYCLE, UPD_DELAY} upd_state_t;

endpackage

// ### rtl/rate_pin_if.sv
// Interface carrying the synchronised rate-reduce pin level and edges.
// Assumes one clock domain shared by producer and consumer.
`timescale 1ns/100ps

interface rate_pin_if;
  logic level;
  logic rise;
  logic fall;
  modport src (output level, output rise, output fall);
  modport dst (input level, input rise, input fall);
endinterface

// ### rtl/rate_pin_sync.sv
// Synchroniser and edge detector for the asynchronous rate-reduce pin.
// Assumes the pin may change at any time relative to the clock.
`timescale 1ns/100ps

module rate_pin_sync
  import rate_pin_pkg::*;
#(
  parameter int STAGES = SYNC_STAGES
) (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Raw pin
  input wire logic i_pin,
  // Synchronised outputs
  rate_pin_if.src pin
);

  generate
    if (STAGES < 2) begin : g_bad_stages
      $error("rate_pin_sync needs at least two stages");
    end
  endgenerate

  logic [STAGES-1:0] sync_r;
  logic [STAGES:0] fill_r;
  logic lvl_r;
  logic rise_r;
  logic fall_r;

  ////////////////////////////////////////////////////////////////////////
  // Synchroniser chain, first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync_r <= '0;
    end else begin
      sync_r <= {sync_r[STAGES-2:0], i_pin};
    end
  end

  // Priming so reset state gives no false edge
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      fill_r <= '0;
    end else begin
      fill_r <= {fill_r[STAGES-1:0], 1'b1};
    end
  end

  // Level and one-cycle edge pulses
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      lvl_r <= 1'b0;
      rise_r <= 1'b0;
      fall_r <= 1'b0;
    end else begin
      lvl_r <= sync_r[STAGES-1];
      rise_r <= fill_r[STAGES] & sync_r[STAGES-1] & ~lvl_r;
      fall_r <= fill_r[STAGES] & ~sync_r[STAGES-1] & lvl_r;
    end
  end

  assign pin.level = lvl_r;
  assign pin.rise = rise_r;
  assign pin.fall = fall_r;

endmodule // rate_pin_sync

// ### rtl/rate_pin_status.sv
// Rate-reduce pin status register, edge-triggered limited updates,
// power-cycle flag and read-only shadow of the active control settings.
// Assumes the host command decoder gives one-cycle register strobes and
// update command pulses, and the conversion engine gives cycle-end and
// overflow pulses on this clock.
`timescale 1ns/100ps

module rate_pin_status
  import rate_pin_pkg::*;
#(
  parameter int UPD_DLY = UPD_CYCLES,
  parameter int CC_LEN = CC_CYCLES
) (
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RESET_N,
  // Rate-reduce pin and its mode
  input wire logic I_RATE_PIN,
  input wire logic I_PIN_IS_ALERT,
  // Register access
  input wire logic [7:0] I_REG_ADDR,
  input wire logic I_REG_WE,
  input wire logic I_REG_RE,
  input wire logic [7:0] I_REG_WDATA,
  output logic [7:0] O_REG_RDATA,
  // Host update commands and pending control value
  input wire logic I_CMD_FULL,
  input wire logic I_CMD_KEEP,
  input wire logic I_CMD_GLOBAL,
  input wire logic [7:0] I_CTRL_PEND,
  // Conversion engine
  input wire logic I_CONV_DONE,
  input wire logic I_ACC_OVF,
  output logic O_LOAD_RESULTS,
  output logic O_CLEAR_ACC,
  output logic [1:0] O_ACT_RATE,
  output logic O_ACT_SLEEP,
  output logic O_ACT_SINGLE,
  // Alert output
  output logic O_ALERT
);

  localparam int CW = $clog2(UPD_DLY + 1);
  localparam int AW = $clog2(CC_LEN + 1);

  generate
    if (UPD_DLY < 2 || CC_LEN < 1) begin : g_bad_params
      $error("rate_pin_status delay counts out of range");
    end
  endgenerate

  rate_pin_if pin ();

  logic rise_seen_r;
  logic fall_seen_r;
  logic [3:0] en_r;
  logic por_r;
  logic [6:0] act_r;
  logic [6:0] pend_r;
  logic full_r;
  logic ovf_flag_r;
  upd_state_t state_r;
  logic [CW-1:0] cnt_r;
  logic [AW-1:0] cc_cnt_r;
  logic [7:0] rdata_r;
  logic load_r;
  logic clear_r;
  logic alert_r;
  logic cmd_any;
  logic cmd_clear;
  logic done_tick;
  logic st_wr;
  logic lim_full;
  logic lim_keep;
  logic [7:0] stat_word;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser
  rate_pin_sync #(
    .STAGES(SYNC_STAGES)
  ) u_sync (
    .i_clk(I_CLK),
    .i_rst_n(I_RESET_N),
    .i_pin(I_RATE_PIN),
    .pin(pin)
  );

  ////////////////////////////////////////////////////////////////////////
  // Decode of commands, writes and edge-triggered updates
  assign cmd_any = I_CMD_FULL | I_CMD_KEEP | I_CMD_GLOBAL;
  assign cmd_clear = I_CMD_FULL | I_CMD_GLOBAL;
  assign st_wr = I_REG_WE && (I_REG_ADDR == ADDR_PIN_STAT);
  assign done_tick = (state_r == UPD_DELAY) && (cnt_r == CW'(1)) && !cmd_any;
  // Full wins over keep for the same edge
  assign lim_full = (pin.rise & en_r[BIT_RISE_FULL-1])
                  | (pin.fall & en_r[BIT_FALL_FULL-1]);
  assign lim_keep = ~lim_full
                  & ((pin.rise & en_r[BIT_RISE_KEEP-1])
                  | (pin.fall & en_r[BIT_FALL_KEEP-1]));
  assign stat_word = {pin.level, rise_seen_r, fall_seen_r, en_r, por_r};

  ////////////////////////////////////////////////////////////////////////
  // Sticky edge flags, set wins over clear
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rise_seen_r <= 1'b0;
      fall_seen_r <= 1'b0;
    end else begin
      if (pin.rise) begin
        rise_seen_r <= 1'b1;
      end else if (cmd_clear) begin
        rise_seen_r <= 1'b0;
      end
      if (pin.fall) begin
        fall_seen_r <= 1'b1;
      end else if (cmd_clear) begin
        fall_seen_r <= 1'b0;
      end
    end
  end

  // Edge update enables, host write only
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      en_r <= EN_RESET;
    end else if (st_wr) begin
      en_r <= I_REG_WDATA[BIT_RISE_FULL:BIT_FALL_KEEP];
    end
  end

  // Power-cycle flag, only reset sets it
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      por_r <= 1'b1;
    end else if (st_wr && !I_REG_WDATA[BIT_POR]) begin
      por_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Host update sequencer: capture, wait for cycle end if the rate changes while awake, then 1 ms delay
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      state_r <= UPD_IDLE;
      cnt_r <= '0;
      pend_r <= ACT_RESET;
      full_r <= 1'b0;
    end else if (cmd_any) begin
      pend_r <= I_CTRL_PEND[7:1];
      full_r <= cmd_clear;
      cnt_r <= CW'(UPD_DLY);
      if (I_CTRL_PEND[7:6] != act_r[6:5] && !act_r[BIT_SLEEP-1]) begin
        state_r <= UPD_WAIT_CYCLE;
      end else begin
        state_r <= UPD_DELAY;
      end
    end else begin
      case (state_r)
        UPD_WAIT_CYCLE: begin
          if (I_CONV_DONE) begin
            state_r <= UPD_DELAY;
          end
        end
        UPD_DELAY: begin
          cnt_r <= cnt_r - CW'(1);
          if (cnt_r == CW'(1)) begin
            state_r <= UPD_IDLE;
          end
        end
        default: begin
          state_r <= UPD_IDLE;
        end
      endcase
    end
  end

  // Active settings change only at the end of a host update
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      act_r <= ACT_RESET;
    end else if (done_tick) begin
      act_r <= pend_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Result load and accumulator clear strobes
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      load_r <= 1'b0;
      clear_r <= 1'b0;
    end else begin
      load_r <= lim_full | lim_keep | done_tick;
      clear_r <= lim_full | (done_tick & full_r);
    end
  end

  // Overflow flag, new overflow wins over clearing
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      ovf_flag_r <= 1'b0;
    end else if (I_ACC_OVF) begin
      ovf_flag_r <= 1'b1;
    end else if (clear_r) begin
      ovf_flag_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Alert: timed pulse on cycle end, level on overflow
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      cc_cnt_r <= '0;
    end else if (I_CONV_DONE && act_r[BIT_CC_ALERT-1]) begin
      cc_cnt_r <= AW'(CC_LEN);
    end else if (cc_cnt_r != '0) begin
      cc_cnt_r <= cc_cnt_r - AW'(1);
    end
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      alert_r <= 1'b0;
    end else begin
      alert_r <= act_r[BIT_ALERT_PIN-1]
               & ((cc_cnt_r != '0)
               | (act_r[BIT_OVERFLOW_ALERT_EN-1] & ovf_flag_r));
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Register read port, no side effects on read
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rdata_r <= 8'h00;
    end else if (I_REG_RE) begin
      case (I_REG_ADDR)
        ADDR_PIN_STAT: begin
          rdata_r <= I_PIN_IS_ALERT ? 8'h00 : stat_word;
        end
        ADDR_ACT_CTRL: rdata_r <= {act_r, ovf_flag_r};
        default: rdata_r <= 8'h00;
      endcase
    end
  end

  // Outputs straight from flip-flops
  assign O_REG_RDATA = rdata_r;
  assign O_LOAD_RESULTS = load_r;
  assign O_CLEAR_ACC = clear_r;
  assign O_ACT_RATE = act_r[6:5];
  assign O_ACT_SLEEP = act_r[BIT_SLEEP-1];
  assign O_ACT_SINGLE = act_r[BIT_SINGLE-1];
  assign O_ALERT = alert_r;

  ////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RESET_N);

  sequence s_rise_full;
    pin.rise && en_r[BIT_RISE_FULL-1];
  endsequence

  sequence s_load_clear;
    O_LOAD_RESULTS && O_CLEAR_ACC;
  endsequence

  sequence s_keep_only;
    O_LOAD_RESULTS && !O_CLEAR_ACC;
  endsequence

  property p_level_read;
    I_REG_RE && I_REG_ADDR == ADDR_PIN_STAT && !I_PIN_IS_ALERT
      |=> O_REG_RDATA[BIT_LEVEL] == $past(pin.level);
  endproperty
  a_level_read: assert property (p_level_read)
    else $error("status level bit mismatch");

  property p_rise_seen;
    pin.rise |=> rise_seen_r;
  endproperty
  a_rise_seen: assert property (p_rise_seen)
    else $error("rise edge not recorded");

  property p_fall_seen;
    pin.fall |=> fall_seen_r;
  endproperty
  a_fall_seen: assert property (p_fall_seen)
    else $error("fall edge not recorded");

  property p_rise_full;
    s_rise_full |=> s_load_clear;
  endproperty
  a_rise_full: assert property (p_rise_full)
    else $error("rising edge full update missing");

  property p_fall_keep;
    pin.fall && en_r[BIT_FALL_KEEP-1] && !en_r[BIT_FALL_FULL-1]
      && !cmd_any && state_r == UPD_IDLE |=> s_keep_only;
  endproperty
  a_fall_keep: assert property (p_fall_keep)
    else $error("falling edge keep update wrong");

  property p_full_wins;
    pin.rise && en_r[BIT_RISE_FULL-1] && en_r[BIT_RISE_KEEP-1]
      |=> O_CLEAR_ACC;
  endproperty
  a_full_wins: assert property (p_full_wins)
    else $error("keep update ran instead of full");

  property p_en_hold;
    !st_wr |=> $stable(en_r);
  endproperty
  a_en_hold: assert property (p_en_hold)
    else $error("edge enables changed without write");

  property p_no_activate;
    (pin.rise || pin.fall) && state_r == UPD_IDLE && !cmd_any
      |=> $stable(act_r);
  endproperty
  a_no_activate: assert property (p_no_activate)
    else $error("edge update activated control");

  property p_alert_mode_zero;
    I_REG_RE && I_REG_ADDR == ADDR_PIN_STAT && I_PIN_IS_ALERT
      |=> O_REG_RDATA == 8'h00;
  endproperty
  a_alert_mode_zero: assert property (p_alert_mode_zero)
    else $error("status not zero in alert mode");

  property p_por_clear;
    st_wr && !I_REG_WDATA[BIT_POR] |=> !por_r ##1 !por_r;
  endproperty
  a_por_clear: assert property (p_por_clear)
    else $error("power-cycle flag not cleared");

  property p_upd_delay;
    I_CMD_KEEP && I_CTRL_PEND[7:6] == act_r[6:5] ##1 !cmd_any [*8]
      |-> !O_LOAD_RESULTS;
  endproperty
  a_upd_delay: assert property (p_upd_delay)
    else $error("results loaded before delay");

  property p_cc_alert;
    $rose(cc_cnt_r != '0) && act_r[BIT_ALERT_PIN-1]
      && $stable(act_r) |=> O_ALERT;
  endproperty
  a_cc_alert: assert property (p_cc_alert)
    else $error("conversion alert not raised");

  // Flag holds unless an accumulator clear follows the set
  property p_ovf_flag;
    I_ACC_OVF |=> ovf_flag_r ##1 (ovf_flag_r || $past(clear_r));
  endproperty
  a_ovf_flag: assert property (p_ovf_flag)
    else $error("overflow flag not held");

endmodule // rate_pin_status

// ### dv/rate_pin_partner.sv
// Model of the external controller driving the rate-reduce pin.
// Assumes the bench requests levels; the pin follows asynchronously.
`timescale 1ns/100ps

module rate_pin_partner (
  // Requested level
  input wire logic i_level,
  // Pin to the device
  output logic o_pin
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin starts low at power-up
  initial begin
    o_pin = 1'b0;
  end

  // Pin follows the request, off the device clock grid
  always @(i_level) begin
    o_pin <= #37 i_level;
  end

endmodule // rate_pin_partner

// ### dv/rate_pin_status_tb.sv
// Self-checking bench for the rate-reduce pin status block.
// Assumes short update and alert counts set through parameters.
`timescale 1ns/100ps

module rate_pin_status_tb;
  import rate_pin_pkg::*;

  localparam int UPD = 8;
  localparam int CCL = 6;

  ////////////////////////////////////////////////////////////////////////////
  // Signals and bench state
  logic I_CLK = 1'b0;
  logic I_RESET_N = 1'b0;
  logic pin_req = 1'b0;
  logic I_RATE_PIN;
  logic I_PIN_IS_ALERT = 1'b0;
  logic [7:0] I_REG_ADDR = 8'h00;
  logic I_REG_WE = 1'b0;
  logic I_REG_RE = 1'b0;
  logic [7:0] I_REG_WDATA = 8'h00;
  logic [7:0] O_REG_RDATA;
  logic I_CMD_FULL = 1'b0;
  logic I_CMD_KEEP = 1'b0;
  logic I_CMD_GLOBAL = 1'b0;
  logic [7:0] I_CTRL_PEND = 8'h00;
  logic I_CONV_DONE = 1'b0;
  logic I_ACC_OVF = 1'b0;
  logic O_LOAD_RESULTS;
  logic O_CLEAR_ACC;
  logic [1:0] O_ACT_RATE;
  logic O_ACT_SLEEP;
  logic O_ACT_SINGLE;
  logic O_ALERT;
  int n_fail = 0;
  int checked = 0;
  int n_ld = 0;
  int n_clr = 0;
  int l0;
  int c0;
  int cnt;
  logic [31:0] rnd = 32'd49;
  logic [7:0] act = 8'h00;
  logic [7:0] rd_v;
  logic [7:0] p;
  logic [3:0] en;

  ////////////////////////////////////////////////////////////////////////////
  // Design and pin partner
  rate_pin_status #(.UPD_DLY(UPD), .CC_LEN(CCL)) i_rate_pin_status (
    .I_CLK(I_CLK), .I_RESET_N(I_RESET_N), .I_RATE_PIN(I_RATE_PIN),
    .I_PIN_IS_ALERT(I_PIN_IS_ALERT), .I_REG_ADDR(I_REG_ADDR),
    .I_REG_WE(I_REG_WE), .I_REG_RE(I_REG_RE), .I_REG_WDATA(I_REG_WDATA),
    .O_REG_RDATA(O_REG_RDATA), .I_CMD_FULL(I_CMD_FULL),
    .I_CMD_KEEP(I_CMD_KEEP), .I_CMD_GLOBAL(I_CMD_GLOBAL),
    .I_CTRL_PEND(I_CTRL_PEND), .I_CONV_DONE(I_CONV_DONE),
    .I_ACC_OVF(I_ACC_OVF), .O_LOAD_RESULTS(O_LOAD_RESULTS),
    .O_CLEAR_ACC(O_CLEAR_ACC), .O_ACT_RATE(O_ACT_RATE),
    .O_ACT_SLEEP(O_ACT_SLEEP), .O_ACT_SINGLE(O_ACT_SINGLE),
    .O_ALERT(O_ALERT));

  rate_pin_partner i_rate_pin_partner (.i_level(pin_req), .o_pin(I_RATE_PIN));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and strobe counters
  always #50 I_CLK = ~I_CLK;

  always @(posedge I_CLK) begin
    if (O_LOAD_RESULTS === 1'b1) n_ld++;
    if (O_CLEAR_ACC === 1'b1) n_clr++;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    return y ^ (y << 5);
  endfunction

  function automatic logic [7:0] stat_exp(input logic l, input logic r,
      input logic f, input logic [3:0] e, input logic po);
    return {l, r, f, e, po};
  endfunction

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp,
      input string what);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what,
               seen, exp);
    end
  endtask

  task automatic close_out;
    if (n_fail == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge I_CLK);
    I_REG_ADDR = a;
    I_REG_RE = 1'b1;
    @(negedge I_CLK);
    I_REG_RE = 1'b0;
    @(negedge I_CLK);
    d = O_REG_RDATA;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge I_CLK);
    I_REG_ADDR = a;
    I_REG_WDATA = d;
    I_REG_WE = 1'b1;
    @(negedge I_CLK);
    I_REG_WE = 1'b0;
  endtask

  task automatic pin_to(input logic v);
    @(negedge I_CLK);
    pin_req = v;
    repeat (8) @(negedge I_CLK);
  endtask

  task automatic pulse(ref logic s);
    @(negedge I_CLK);
    s = 1'b1;
    @(negedge I_CLK);
    s = 1'b0;
  endtask

  // Host update command; waits for the cycle end when the rate changes and the active sleep bit is clear
  task automatic cmd(input int kind, input logic [7:0] pv);
    int n;
    int lb;
    int cb;
    logic cw;
    cw = (pv[7:6] !== act[7:6]) && !act[5];
    @(negedge I_CLK);
    I_CTRL_PEND = pv;
    I_CMD_FULL = (kind == 0);
    I_CMD_KEEP = (kind == 1);
    I_CMD_GLOBAL = (kind == 2);
    lb = n_ld;
    cb = n_clr;
    @(negedge I_CLK);
    {I_CMD_FULL, I_CMD_KEEP, I_CMD_GLOBAL} = 3'h0;
    if (cw) begin
      repeat (UPD + 6) @(negedge I_CLK);
      chk(8'(n_ld - lb), 8'h00, "load before cycle end");
      pulse(I_CONV_DONE);
    end
    n = 0;
    while (n_ld == lb && n < UPD + 8) begin
      @(negedge I_CLK);
      n++;
    end
    if (n_ld == lb) begin
      n_fail++;
      $display("CHECK FAILED at %0t: update never completed", $time);
      close_out;
    end
    chk(8'(n >= UPD && n <= UPD + 4), 8'h01, "update delay");
    chk(8'(n_clr - cb), 8'(kind != 1), "accumulator clear");
    act = {pv[7:1], (kind == 1) ? act[0] : 1'b0};
    @(negedge I_CLK);
    chk({O_ACT_RATE, O_ACT_SLEEP, O_ACT_SINGLE, 4'h0}, {act[7:4], 4'h0},
        "active outputs");
    rd(ADDR_ACT_CTRL, rd_v);
    chk(rd_v, act, "shadow");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    rnd = xs(rnd);
    I_CTRL_PEND = rnd[7:0];
    repeat (10) @(negedge I_CLK);
    I_RESET_N = 1'b1;
    rd(ADDR_PIN_STAT, rd_v);
    chk(rd_v, stat_exp(0, 0, 0, EN_RESET, 1), "status at reset");
    rd(8'h7f, rd_v);
    chk(rd_v, 8'h00, "unmapped read");
    wr(ADDR_ACT_CTRL, 8'hff);
    rd(ADDR_ACT_CTRL, rd_v);
    chk(rd_v, 8'h00, "shadow write ignored");
    // Edges with reset enables and a pending value never commanded
    l0 = n_ld;
    c0 = n_clr;
    pin_to(1'b1);
    chk(8'(n_ld - l0), 8'h01, "rise load");
    chk(8'(n_clr - c0), 8'h01, "rise clear");
    rd(ADDR_PIN_STAT, rd_v);
    chk(rd_v, stat_exp(1, 1, 0, EN_RESET, 1), "after rise");
    rd(ADDR_ACT_CTRL, rd_v);
    chk(rd_v, 8'h00, "shadow after edge update");
    pin_to(1'b0);
    rd(ADDR_PIN_STAT, rd_v);
    chk(rd_v, stat_exp(0, 1, 1, EN_RESET, 1), "after fall");
    rd(ADDR_PIN_STAT, rd_v);
    chk(rd_v, stat_exp(0, 1, 1, EN_RESET, 1), "second read");
    I_PIN_IS_ALERT = 1'b1;
    rd(ADDR_PIN_STAT, rd_v);
    chk(rd_v, 8'h00, "alert mode status");
    I_PIN_IS_ALERT = 1'b0;
    wr(ADDR_PIN_STAT, 8'he0);
    wr(ADDR_PIN_STAT, 8'h01);
    rd(ADDR_PIN_STAT, rd_v);
    chk(rd_v, stat_exp(0, 1, 1, 4'h0, 0), "power flag cleared");
    // Random edge enables, corners: all four set, then keep only
    for (int i = 0; i < 8; i++) begin
      rnd = xs(rnd);
      en = (i == 0) ? 4'hf : (i == 1) ? 4'h5 : rnd[3:0];
      wr(ADDR_PIN_STAT, {3'h0, en, 1'b1});
      cmd((i % 2 == 0) ? 0 : 2, act);
      rd(ADDR_PIN_STAT, rd_v);
      chk(rd_v, stat_exp(0, 0, 0, en, 0), "flags cleared");
      l0 = n_ld;
      c0 = n_clr;
      pin_to(1'b1);
      chk(8'(n_ld - l0), 8'(en[3] | en[2]), "rise load");
      chk(8'(n_clr - c0), 8'(en[3]), "rise clear");
      rd(ADDR_PIN_STAT, rd_v);
      chk(rd_v, stat_exp(1, 1, 0, en, 0), "after rise");
      l0 = n_ld;
      c0 = n_clr;
      pin_to(1'b0);
      chk(8'(n_ld - l0), 8'(en[1] | en[0]), "fall load");
      chk(8'(n_clr - c0), 8'(en[1]), "fall clear");
      rd(ADDR_PIN_STAT, rd_v);
      chk(rd_v, stat_exp(0, 1, 1, en, 0), "after fall");
    end
    // Every rate code, every command kind, sleep in between
    for (int i = 0; i < 6; i++) begin
      rnd = xs(rnd);
      p = {2'(i), (i == 4), rnd[4:0]};
      cmd(i % 3, p);
    end
    // Conversion-complete and overflow alerts
    p = {act[7:6], 2'h0, 3'h7, 1'b0};
    cmd(1, p);
    pulse(I_CONV_DONE);
    cnt = 0;
    repeat (20) begin
      @(negedge I_CLK);
      if (O_ALERT === 1'b1) cnt++;
    end
    chk(8'(cnt), 8'(CCL), "cycle-end alert length");
    pulse(I_ACC_OVF);
    repeat (3) @(negedge I_CLK);
    chk({7'h0, O_ALERT}, 8'h01, "overflow alert");
    act[0] = 1'b1;
    rd(ADDR_ACT_CTRL, rd_v);
    chk(rd_v, act, "overflow flag set");
    cmd(0, p);
    chk({7'h0, O_ALERT}, 8'h00, "alert after clear");
    p[3] = 1'b0;
    cmd(1, p);
    pulse(I_ACC_OVF);
    repeat (3) @(negedge I_CLK);
    chk({7'h0, O_ALERT}, 8'h00, "alert pin disabled");
    // Mid-run reset brings the power-cycle flag back
    @(negedge I_CLK);
    I_RESET_N = 1'b0;
    repeat (2) @(negedge I_CLK);
    I_RESET_N = 1'b1;
    act = 8'h00;
    rd(ADDR_PIN_STAT, rd_v);
    chk(rd_v, stat_exp(0, 0, 0, EN_RESET, 1), "flag after reset");
    rd(ADDR_ACT_CTRL, rd_v);
    chk(rd_v, act, "shadow after reset");
    close_out;
  end

endmodule // rate_pin_status_tb
